// File: hw/fh_pkg.sv
// Constants for the serial flash program and erase host
package fh_pkg;
    localparam int          AW           = 5;
    localparam logic [4:0]  REG_CTRL     = 5'h00;
    localparam logic [4:0]  REG_ADDR     = 5'h04;
    localparam logic [4:0]  REG_LEN      = 5'h08;
    localparam logic [4:0]  REG_DATA     = 5'h0c;
    localparam logic [4:0]  REG_STATUS   = 5'h10;
    localparam int          CTRL_START   = 8;
    localparam int          CTRL_A4      = 9;
    localparam int          SR_BUSY      = 0;
    localparam int          SR_WEL       = 1;
    localparam int          SR2_QE       = 1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [7:0]  OP_WREN      = 8'h06;
    localparam logic [7:0]  OP_RDSR1     = 8'h05;
    localparam logic [7:0]  OP_RDSR2     = 8'h35;
    localparam logic [7:0]  OP_PP        = 8'h02;
    localparam logic [7:0]  OP_PP4       = 8'h12;
    localparam logic [7:0]  OP_QPP       = 8'h32;
    localparam logic [7:0]  OP_QPP4      = 8'h34;
    localparam logic [7:0]  OP_SE        = 8'h20;
    localparam logic [7:0]  OP_SE4       = 8'h21;
    localparam logic [7:0]  OP_BE32      = 8'h52;
    localparam logic [7:0]  OP_BE64      = 8'hd8;
    localparam logic [7:0]  OP_BE64_4    = 8'hdc;
    localparam logic [7:0]  OP_CE1       = 8'hc7;
    localparam logic [7:0]  OP_CE2       = 8'h60;
    localparam logic [3:0]  IO_IDLE      = 4'hc;
    localparam logic [3:0]  OE_IDLE      = 4'hc;
    localparam logic [3:0]  OE_SER       = 4'hd;
    localparam logic [3:0]  OE_QUAD      = 4'hf;
    localparam logic [7:0]  HALF_DIV_DEF = 8'h04;
    localparam logic [7:0]  CS_GAP_DEF   = 8'h08;
endpackage

// File: hw/flash_host.sv
`timescale 1ns/1ns
// SPI host that runs program and erase sequences on a serial NOR flash
module flash_host #(
    parameter logic [7:0] HALF_DIV = fh_pkg::HALF_DIV_DEF,
    parameter logic [7:0] CS_GAP   = fh_pkg::CS_GAP_DEF
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [fh_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [fh_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       flash_cs_n,
    output logic                       flash_sck,
    output logic [3:0]                 flash_io_o,
    output logic [3:0]                 flash_io_oe,
    input  wire logic [3:0]            flash_io_i
);
    import fh_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WREN   = 3'b001,
        ST_CHKWEL = 3'b010,
        ST_CHKQE  = 3'b011,
        ST_CMD    = 3'b100,
        ST_POLL   = 3'b101
    } seq_e;

    typedef struct packed {
        seq_e             st;
        logic [255:0][7:0] pbuf;
        logic [7:0]       wptr;
        logic [7:0]       len_m1;
        logic [7:0]       op;
        logic [31:0]      addr;
        logic             a4;
        logic             done;
        logic             e_wel;
        logic             e_qe;
        logic             e_op;
        logic [7:0]       sr;
        logic             fr_on;
        logic             fcmd;
        logic             quad_fr;
        logic [7:0]       fop;
        logic [8:0]       fr_len;
        logic [8:0]       bidx;
        logic [2:0]       bcnt;
        logic [7:0]       sh;
        logic [7:0]       rx;
        logic [7:0]       div;
        logic [7:0]       gap;
        logic [2:0]       sync;
        logic             miso;
        logic             cs_n;
        logic             sck;
        logic [3:0]       io_o;
        logic [3:0]       io_oe;
        logic             aw_h;
        logic             w_h;
        logic [AW-1:0]    aw_a;
        logic [31:0]      w_d;
        logic [3:0]       w_s;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } state_s;

    localparam state_s RST = '{st: ST_IDLE, cs_n: 1'b1, io_o: IO_IDLE, io_oe: OE_IDLE,
                               awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    state_s r_ff;
    state_s nxt_r;

    function automatic logic [2:0] addr_len(input logic [7:0] op, input logic a4);
        unique case (op)
            OP_PP4, OP_QPP4, OP_SE4, OP_BE64_4: return 3'h4;
            OP_CE1, OP_CE2:                     return 3'h0;
            default:                            return a4 ? 3'h4 : 3'h3;
        endcase
    endfunction

    function automatic logic is_prog(input logic [7:0] op);
        return op == OP_PP || op == OP_PP4 || op == OP_QPP || op == OP_QPP4;
    endfunction

    function automatic logic is_quad(input logic [7:0] op);
        return op == OP_QPP || op == OP_QPP4;
    endfunction

    function automatic logic op_ok(input logic [7:0] op);
        return is_prog(op) || op == OP_SE || op == OP_SE4 || op == OP_BE32 || op == OP_BE64
               || op == OP_BE64_4 || op == OP_CE1 || op == OP_CE2;
    endfunction

    // Byte idx of the current frame: opcode, address MSB first, then page data
    function automatic logic [7:0] frame_byte(input state_s s, input logic [8:0] idx);
        logic [8:0] al;
        logic [8:0] k;
        al = {6'h00, addr_len(s.op, s.a4)};
        k  = al - idx;
        if (idx == 9'h000) return s.fop;
        if (!s.fcmd) return 8'h00;
        if (idx <= al) return s.addr[{k[1:0], 3'b000} +: 8];
        return s.pbuf[8'(idx - 9'h001 - al)];
    endfunction

    function automatic logic is_qbyte(input state_s s, input logic [8:0] idx);
        return s.quad_fr && idx > {6'h00, addr_len(s.op, s.a4)};
    endfunction

    // WP and HOLD lines held high whenever the pins are not carrying quad data
    function automatic state_s drive(input state_s s, input logic q);
        s.io_o  = q ? s.sh[7:4] : {2'b11, 1'b0, s.sh[7]};
        s.io_oe = q ? OE_QUAD : OE_SER;
        return s;
    endfunction

    function automatic state_s launch(input state_s s, input logic [7:0] fop, input logic cmd);
        s.fr_on   = 1'b1;
        s.cs_n    = 1'b0;
        s.sck     = 1'b0;
        s.fop     = fop;
        s.fcmd    = cmd;
        s.quad_fr = cmd && is_quad(s.op);
        s.fr_len  = cmd ? 9'h001 + {6'h00, addr_len(s.op, s.a4)}
                          + (is_prog(s.op) ? {1'b0, s.len_m1} + 9'h001 : 9'h000)
                        : (fop == OP_WREN ? 9'h001 : 9'h002);
        s.bidx    = 9'h000;
        s.bcnt    = 3'h7;
        s.div     = 8'h00;
        s.sh      = fop;
        return drive(s, 1'b0);
    endfunction

    always_comb begin
        logic       q;
        logic       fdone;
        logic [4:0] wa;
        q     = 1'b0;
        fdone = !r_ff.fr_on && r_ff.gap == 8'h00;
        wa    = {r_ff.aw_a[AW-1:2], 2'b00};
        nxt_r = r_ff;

        // Flash data-out synchroniser; only agreeing later stages update miso
        nxt_r.sync = {r_ff.sync[1:0], flash_io_i[1]};
        if (r_ff.sync[1] == r_ff.sync[2]) begin
            nxt_r.miso = r_ff.sync[2];
        end

        // Serial engine, mode 0: drive after the falling edge, sample before it
        if (r_ff.fr_on) begin
            nxt_r.div = r_ff.div + 8'h01;
            if (r_ff.div == HALF_DIV - 8'h01) begin
                nxt_r.div = 8'h00;
                nxt_r.sck = ~r_ff.sck;
                if (r_ff.sck) begin
                    nxt_r.rx = {r_ff.rx[6:0], r_ff.miso};
                    q = is_qbyte(r_ff, r_ff.bidx);
                    if (r_ff.bcnt != 3'h0) begin
                        nxt_r.bcnt = r_ff.bcnt - 3'h1;
                        nxt_r.sh   = q ? {r_ff.sh[3:0], 4'h0} : {r_ff.sh[6:0], 1'b0};
                        nxt_r      = drive(nxt_r, q);
                    end else if (r_ff.bidx == r_ff.fr_len - 9'h001) begin
                        nxt_r.sr    = nxt_r.rx;
                        nxt_r.fr_on = 1'b0;
                        nxt_r.cs_n  = 1'b1;
                        nxt_r.io_o  = IO_IDLE;
                        nxt_r.io_oe = OE_IDLE;
                        nxt_r.gap   = CS_GAP;
                    end else begin
                        nxt_r.bidx = r_ff.bidx + 9'h001;
                        q          = is_qbyte(r_ff, nxt_r.bidx);
                        nxt_r.sh   = frame_byte(r_ff, nxt_r.bidx);
                        nxt_r.bcnt = q ? 3'h1 : 3'h7;
                        nxt_r      = drive(nxt_r, q);
                    end
                end
            end
        end else if (r_ff.gap != 8'h00) begin
            nxt_r.gap = r_ff.gap - 8'h01;
        end

        // Sequencer steps only between frames, after the chip select gap
        if (fdone) begin
            unique case (r_ff.st)
                ST_IDLE: begin
                end
                ST_WREN: begin
                    nxt_r    = launch(nxt_r, OP_RDSR1, 1'b0);
                    nxt_r.st = ST_CHKWEL;
                end
                ST_CHKWEL: begin
                    if (!r_ff.sr[SR_WEL]) begin
                        nxt_r.e_wel = 1'b1;
                        nxt_r.done  = 1'b1;
                        nxt_r.st    = ST_IDLE;
                    end else if (is_quad(r_ff.op)) begin
                        nxt_r    = launch(nxt_r, OP_RDSR2, 1'b0);
                        nxt_r.st = ST_CHKQE;
                    end else begin
                        nxt_r    = launch(nxt_r, r_ff.op, 1'b1);
                        nxt_r.st = ST_CMD;
                    end
                end
                ST_CHKQE: begin
                    if (!r_ff.sr[SR2_QE]) begin
                        nxt_r.e_qe = 1'b1;
                        nxt_r.done = 1'b1;
                        nxt_r.st   = ST_IDLE;
                    end else begin
                        nxt_r    = launch(nxt_r, r_ff.op, 1'b1);
                        nxt_r.st = ST_CMD;
                    end
                end
                ST_CMD: begin
                    nxt_r    = launch(nxt_r, OP_RDSR1, 1'b0);
                    nxt_r.st = ST_POLL;
                end
                ST_POLL: begin
                    if (r_ff.sr[SR_BUSY]) begin
                        nxt_r = launch(nxt_r, OP_RDSR1, 1'b0);
                    end else begin
                        nxt_r.done = 1'b1;
                        nxt_r.st   = ST_IDLE;
                    end
                end
                default: begin
                    nxt_r.st = ST_IDLE;
                end
            endcase
        end

        // AXI4-Lite write path; address and data are taken in either order
        if (r_ff.awready && s_axi_awvalid) begin
            nxt_r.aw_h = 1'b1;
            nxt_r.aw_a = s_axi_awaddr;
        end
        if (r_ff.wready && s_axi_wvalid) begin
            nxt_r.w_h = 1'b1;
            nxt_r.w_d = s_axi_wdata;
            nxt_r.w_s = s_axi_wstrb;
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (r_ff.aw_h && r_ff.w_h && !r_ff.bvalid) begin
            nxt_r.aw_h   = 1'b0;
            nxt_r.w_h    = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp  = RESP_OKAY;
            // Settings are frozen while a sequence runs so frames stay coherent
            unique case (wa)
                REG_CTRL: begin
                    if (r_ff.w_s[0] && r_ff.st == ST_IDLE) begin
                        nxt_r.op = r_ff.w_d[7:0];
                        nxt_r.a4 = r_ff.w_d[CTRL_A4];
                        if (r_ff.w_d[CTRL_START]) begin
                            nxt_r.done  = 1'b0;
                            nxt_r.e_wel = 1'b0;
                            nxt_r.e_qe  = 1'b0;
                            nxt_r.e_op  = !op_ok(r_ff.w_d[7:0]);
                            if (!op_ok(r_ff.w_d[7:0])) begin
                                nxt_r.done = 1'b1;
                            end else begin
                                nxt_r    = launch(nxt_r, OP_WREN, 1'b0);
                                nxt_r.st = ST_WREN;
                            end
                        end
                    end
                end
                REG_ADDR: begin
                    if (r_ff.st == ST_IDLE) nxt_r.addr = r_ff.w_d;
                end
                REG_LEN: begin
                    if (r_ff.w_s[0] && r_ff.st == ST_IDLE) begin
                        nxt_r.len_m1 = r_ff.w_d[7:0];
                        nxt_r.wptr   = 8'h00;
                    end
                end
                REG_DATA: begin
                    if (r_ff.w_s[0] && r_ff.st == ST_IDLE) begin
                        nxt_r.pbuf[r_ff.wptr] = r_ff.w_d[7:0];
                        nxt_r.wptr            = r_ff.wptr + 8'h01;
                    end
                end
                REG_STATUS: begin
                end
                default: begin
                    nxt_r.bresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_r.awready = !nxt_r.aw_h;
        nxt_r.wready  = !nxt_r.w_h;

        // AXI4-Lite read path
        if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (r_ff.arready && s_axi_arvalid) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp  = RESP_OKAY;
            unique case ({s_axi_araddr[AW-1:2], 2'b00})
                REG_CTRL:   nxt_r.rdata = {22'h0, r_ff.a4, 1'b0, r_ff.op};
                REG_ADDR:   nxt_r.rdata = r_ff.addr;
                REG_LEN:    nxt_r.rdata = {24'h000000, r_ff.len_m1};
                REG_DATA:   nxt_r.rdata = 32'h00000000;
                REG_STATUS: nxt_r.rdata = {16'h0000, r_ff.sr, 3'h0, r_ff.e_op, r_ff.e_qe,
                                           r_ff.e_wel, r_ff.done, r_ff.st != ST_IDLE};
                default: begin
                    nxt_r.rdata = 32'h00000000;
                    nxt_r.rresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_r.arready = !nxt_r.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign s_axi_awready = r_ff.awready;
    assign s_axi_wready  = r_ff.wready;
    assign s_axi_bresp   = r_ff.bresp;
    assign s_axi_bvalid  = r_ff.bvalid;
    assign s_axi_arready = r_ff.arready;
    assign s_axi_rdata   = r_ff.rdata;
    assign s_axi_rresp   = r_ff.rresp;
    assign s_axi_rvalid  = r_ff.rvalid;
    assign flash_cs_n    = r_ff.cs_n;
    assign flash_sck     = r_ff.sck;
    assign flash_io_o    = r_ff.io_o;
    assign flash_io_oe   = r_ff.io_oe;
endmodule // flash_host

// File: test/flash_host_props.sv
// Assertion checker for the flash host bus and serial link
`timescale 1ns/1ns
module flash_host_props #(
    parameter logic [7:0] HALF_DIV = fh_pkg::HALF_DIV_DEF,
    parameter logic [7:0] CS_GAP   = fh_pkg::CS_GAP_DEF
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       flash_cs_n,
    input wire logic       flash_sck,
    input wire logic [3:0] flash_io_o,
    input wire logic [3:0] flash_io_oe
);
    import fh_pkg::*;
    logic [7:0]  hi_cnt_ff;
    logic [7:0]  gap_cnt_ff;
    logic [11:0] bit_cnt_ff;
    logic        sck_q_ff;
    // Quad clocks carry four bits, so every legal frame ends on a multiple of eight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt_ff  <= 8'h00;
            gap_cnt_ff <= 8'hff;
            bit_cnt_ff <= 12'h000;
            sck_q_ff   <= 1'b0;
        end else begin
            hi_cnt_ff  <= flash_sck ? hi_cnt_ff + 8'h01 : 8'h00;
            gap_cnt_ff <= !flash_cs_n ? 8'h00 : gap_cnt_ff + {7'h00, gap_cnt_ff != 8'hff};
            bit_cnt_ff <= flash_cs_n ? 12'h000 : bit_cnt_ff + ((flash_sck && !sck_q_ff) ?
                          (flash_io_oe == OE_QUAD ? 12'h004 : 12'h001) : 12'h000);
            sck_q_ff   <= flash_sck;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_sck_idle: assert property (flash_cs_n |-> !flash_sck) else $error("clock high while deselected");
    a_lines_idle: assert property (flash_cs_n |-> flash_io_oe == OE_IDLE) else $error("lines driven while idle");
    a_sck_high_len: assert property ($fell(flash_sck) |-> hi_cnt_ff == HALF_DIV) else $error("clock high time");
    a_data_steady: assert property (flash_sck && $past(flash_sck) |-> $stable(flash_io_o) && $stable(flash_io_oe))
        else $error("data changed while clock high");
    a_cs_byte_end: assert property ($rose(flash_cs_n) |-> bit_cnt_ff[2:0] == 3'h0 && bit_cnt_ff != 12'h000
        && $past(flash_sck)) else $error("select rose off a byte end");
    a_cs_gap: assert property ($fell(flash_cs_n) |-> gap_cnt_ff >= CS_GAP) else $error("select gap too short");
    a_hold_high: assert property (flash_io_oe != OE_QUAD |-> flash_io_o[3:2] == 2'h3) else $error("upper lines low");
    a_b_follow: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    c_quad: cover property (flash_io_oe == OE_QUAD);
    c_frame_end: cover property ($rose(flash_cs_n));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // flash_host_props
bind flash_host flash_host_props #(.HALF_DIV(HALF_DIV), .CS_GAP(CS_GAP)) props_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .flash_cs_n(flash_cs_n), .flash_sck(flash_sck),
    .flash_io_o(flash_io_o), .flash_io_oe(flash_io_oe));

// File: test/flash_model.sv
// Behavioural serial NOR flash answering program, erase and status commands
`timescale 1ns/1ns
module flash_model (
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic [3:0]  io,
    input  wire logic        qe,
    input  wire logic        a4,
    input  wire logic        wren_ok,
    input  wire logic [15:0] busy_ns,
    output logic             so
);
    logic [7:0]  op;
    logic [7:0]  sh;
    logic [7:0]  sr;
    logic [7:0]  last_op;
    logic [7:0]  pg [256];
    logic [31:0] addr;
    logic [31:0] last_addr;
    logic        pe;
    logic        pp;
    logic        write_enable_latch = 1'b0;
    logic        busy = 1'b0;
    int          nb, al, dcnt, last_ab, last_n;
    int          cmd_cnt = 0;
    int          rd_cnt = 0;
    initial so = 1'b0;
    function automatic int alen(input logic [7:0] o);
        case (o)
            8'h12, 8'h34, 8'h21, 8'hdc: return 32;
            8'hc7, 8'h60: return 0;
            default: return a4 ? 32 : 24;
        endcase
    endfunction
    always @(negedge cs_n) begin
        nb = 0;
        dcnt = 0;
        op = 8'h00;
        addr = 32'h0;
    end
    always @(posedge sck) begin
        if (!cs_n) begin
            if (nb < 8) begin
                op = {op[6:0], io[0]};
                nb++;
                if (nb == 8) begin
                    al = alen(op);
                    sr = (op == 8'h05) ? {6'h00, write_enable_latch, busy} : {6'h00, qe, 1'b0};
                    rd_cnt += (op == 8'h05);
                end
            end else if (nb < 8 + al) begin
                addr = {addr[30:0], io[0]};
                nb++;
            end else begin
                sh = (op inside {8'h32, 8'h34}) ? {sh[3:0], io} : {sh[6:0], io[0]};
                nb += (op inside {8'h32, 8'h34}) ? 4 : 1;
                if ((nb - al) % 8 == 0) begin
                    pg[addr[7:0] + dcnt[7:0]] = sh;
                    dcnt++;
                end
            end
        end
    end
    always @(negedge sck) begin
        if (!cs_n && nb >= 8) begin
            so = sr[7];
            sr = {sr[6:0], sr[7]};
        end
    end
    always @(posedge cs_n) begin
        // A released output must not look like held data
        so = ~so;
        if (nb >= 8 && nb % 8 == 0 && !busy) begin
            pe = op inside {8'h20, 8'h21, 8'h52, 8'hd8, 8'hdc, 8'hc7, 8'h60} && nb == 8 + al;
            pp = op inside {8'h02, 8'h12} || (op inside {8'h32, 8'h34} && qe);
            if (op == 8'h06 && wren_ok) begin
                write_enable_latch = 1'b1;
            end else if (write_enable_latch && (pe || (pp && dcnt > 0))) begin
                busy = 1'b1;
                cmd_cnt++;
                last_op = op;
                last_addr = addr;
                last_ab = al;
                last_n = dcnt;
            end
        end
    end
    always @(posedge busy) begin
        #(busy_ns);
        busy = 1'b0;
        write_enable_latch = 1'b0;
    end
endmodule // flash_model

// File: test/flash_host_bench.sv
// Self-checking bench for the flash program and erase host
`timescale 1ns/1ns
module flash_host_bench;
    import fh_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, qe = 1'b1, a4 = 1'b0, wren_ok = 1'b1;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [15:0] busy_ns = 16'h0bb8;
    logic        awready, wready, bvalid, arready, rvalid, cs_n, sck, so;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  io_o, io_oe, io_i;
    int          error_cnt = 0, checked = 0;
    logic [7:0]  ops [7] = '{8'h20, 8'h21, 8'h52, 8'hd8, 8'hdc, 8'hc7, 8'h60};
    always #5 aclk = ~aclk;
    assign io_i = {io_o[3:2], io_oe[1] ? io_o[1] : so, io_oe[0] ? io_o[0] : ~io_o[0]};
    flash_host dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_cs_n(cs_n),
        .flash_sck(sck), .flash_io_o(io_o), .flash_io_oe(io_oe), .flash_io_i(io_i));
    flash_model fm_u (.cs_n(cs_n), .sck(sck), .io(io_i), .qe(qe), .a4(a4), .wren_ok(wren_ok),
        .busy_ns(busy_ns), .so(so));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stall;
        chk("timeout", 32'h0, 32'h1);
        tally_and_finish;
    endtask
    // Ready lines drop once a beat is held, and each valid drops on the edge that sees its ready, so no beat is taken twice
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!awvalid && !wvalid && bvalid) break;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 100) stall;
        chk("bresp", er, bresp);
    endtask
    task automatic axi_rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!arvalid && rvalid) break;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n == 100) stall;
        d = rdata;
        chk("rresp", er, rresp);
    endtask
    task automatic run_op(input logic [7:0] op, input logic m4, input logic [31:0] ad, input int nb,
                          output logic [31:0] st);
        int k;
        a4 <= m4;
        axi_wr(REG_ADDR, ad, RESP_OKAY);
        axi_wr(REG_LEN, nb - 1, RESP_OKAY);
        for (k = 0; k < nb; k++) axi_wr(REG_DATA, k * 7 + 1, RESP_OKAY);
        axi_wr(REG_CTRL, {22'h0, m4, 1'b1, op}, RESP_OKAY);
        st = 32'h0;
        for (k = 0; k < 3000 && st[1] !== 1'b1; k++) axi_rd(REG_STATUS, RESP_OKAY, st);
        if (st[1] !== 1'b1) stall;
    endtask
    initial begin
        logic [31:0] st, d;
        int          c0, r0, i, j, ab;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk("cs_n", 32'h1, cs_n);
        chk("oe", OE_IDLE, io_oe);
        axi_wr(5'h14, 32'h0, RESP_SLVERR);
        axi_rd(5'h14, RESP_SLVERR, d);
        chk("unmapped", 32'h0, d);
        $display("test reset and map done");
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 7; i++) begin
                busy_ns <= j ? 16'h00c8 : 16'h0bb8;
                c0 = fm_u.cmd_cnt;
                r0 = fm_u.rd_cnt;
                run_op(ops[i], j[0], 32'h1a2b_3c4d, 1, st);
                ab = (ops[i] inside {8'h21, 8'hdc}) ? 32 : (ops[i] inside {8'hc7, 8'h60}) ? 0 : (j ? 32 : 24);
                chk("erase op", ops[i], fm_u.last_op);
                chk("addr bits", ab, fm_u.last_ab);
                chk("addr", ab == 32 ? 32'h1a2b_3c4d : ab == 24 ? 32'h002b_3c4d : 32'h0, fm_u.last_addr);
                chk("runs", c0 + 1, fm_u.cmd_cnt);
                chk("status", 32'h2, st[15:0]);
                if (j == 0) chk("polls", 32'h1, fm_u.rd_cnt - r0 > 2);
            end
        end
        $display("test erase done");
        run_op(OP_PP, 1'b0, 32'h00ab_cdfe, 4, st);
        chk("pp first", 32'h01, fm_u.pg[8'hfe]);
        chk("pp wrap lo", 32'h0f, fm_u.pg[8'h00]);
        chk("pp wrap hi", 32'h16, fm_u.pg[8'h01]);
        chk("pp count", 32'h4, fm_u.last_n);
        run_op(OP_PP4, 1'b0, 32'h0400_0010, 1, st);
        chk("pp4 bits", 32'h20, fm_u.last_ab);
        chk("pp4 addr", 32'h0400_0010, fm_u.last_addr);
        $display("test program done");
        qe <= 1'b0;
        c0 = fm_u.cmd_cnt;
        run_op(OP_QPP, 1'b0, 32'h0000_1000, 2, st);
        chk("qe refuse", 32'h0a, st[4:0]);
        chk("qe runs", c0, fm_u.cmd_cnt);
        qe <= 1'b1;
        run_op(OP_QPP4, 1'b0, 32'h0000_1020, 3, st);
        chk("qpp4 bits", 32'h20, fm_u.last_ab);
        chk("qpp4 data", 32'h0f, fm_u.pg[8'h22]);
        chk("qpp4 status", 32'h2, st[15:0]);
        run_op(OP_QPP, 1'b1, 32'h0000_2030, 2, st);
        chk("qpp bits", 32'h20, fm_u.last_ab);
        chk("qpp data", 32'h08, fm_u.pg[8'h31]);
        $display("test quad done");
        wren_ok <= 1'b0;
        c0 = fm_u.cmd_cnt;
        run_op(OP_SE, 1'b0, 32'h0, 1, st);
        chk("wel refuse", 32'h06, st[4:0]);
        chk("wel runs", c0, fm_u.cmd_cnt);
        wren_ok <= 1'b1;
        run_op(8'h99, 1'b0, 32'h0, 1, st);
        chk("bad op", 32'h12, st[4:0]);
        chk("bad op runs", c0, fm_u.cmd_cnt);
        $display("test refusals done");
        tally_and_finish;
    end
endmodule // flash_host_bench
